// ### pkg/pfs_pkg.sv
package pfs_pkg;

	localparam int PFS_DW = 8;
	localparam int PFS_AW = 8;

	localparam logic [PFS_AW-1:0] PFS_ADDR_PORT_OUT = 8'h00;
	localparam logic [PFS_AW-1:0] PFS_ADDR_PORT_IN  = 8'h10;
	localparam logic [PFS_AW-1:0] PFS_ADDR_PORT_DIR = 8'h20;
	localparam logic [PFS_AW-1:0] PFS_ADDR_MODE     = 8'h40;
	localparam logic [PFS_AW-1:0] PFS_ADDR_ALT_SEL  = 8'h70;
	localparam logic [PFS_AW-1:0] PFS_ADDR_ROUTE    = 8'h78;
	localparam logic [PFS_AW-1:0] PFS_ADDR_STATUS   = 8'h7f;

	localparam logic [PFS_DW-1:0] PFS_RST_MODE    = 8'h00;
	localparam logic [PFS_DW-1:0] PFS_RST_ALT_SEL = 8'h00;
	localparam logic [PFS_DW-1:0] PFS_RST_OUT     = 8'h00;
	localparam logic [PFS_DW-1:0] PFS_RST_DIR     = 8'hff;
	localparam logic [PFS_DW-1:0] PFS_RST_STATUS  = 8'h00;
	localparam logic [PFS_DW-1:0] PFS_ZERO        = 8'h00;

	localparam logic [PFS_DW-1:0] PFS_MASK_MODE    = 8'h7f;
	localparam logic [PFS_DW-1:0] PFS_MASK_ALT_SEL = 8'h0b;
	localparam logic [PFS_DW-1:0] PFS_MASK_PORT    = 8'h7f;
	localparam logic [PFS_DW-1:0] PFS_MASK_ROUTE   = 8'h07;
	localparam logic [PFS_DW-1:0] PFS_MASK_STATUS  = 8'h03;
	localparam logic [PFS_DW-1:0] PFS_PIN_PRESENT  = 8'h7f;

	localparam int PFS_PIN3_IDX       = 3;
	localparam int PFS_ROUTE_IRQ0     = 0;
	localparam int PFS_ROUTE_ADC      = 1;
	localparam int PFS_ROUTE_PIN3     = 2;
	localparam int PFS_STAT_UNMAPPED  = 0;
	localparam int PFS_STAT_BAD_BIT   = 1;

	typedef enum logic [1:0] {
		PFS_BOP_WRITE  = 2'h0,
		PFS_BOP_SET    = 2'h1,
		PFS_BOP_CLEAR  = 2'h2,
		PFS_BOP_TOGGLE = 2'h3
	} pfs_bitop_t;

	typedef struct packed {
		logic       en;
		logic [2:0] idx;
		pfs_bitop_t op;
	} pfs_bitacc_t;

	typedef struct packed {
		logic irq0;
		logic adc_trig;
	} pfs_alt_in_t;

	typedef enum logic [2:0] {
		PFS_SEL_NONE   = 3'h0,
		PFS_SEL_OUT    = 3'h1,
		PFS_SEL_IN     = 3'h2,
		PFS_SEL_DIR    = 3'h3,
		PFS_SEL_MODE   = 3'h4,
		PFS_SEL_ALT    = 3'h5,
		PFS_SEL_ROUTE  = 3'h6,
		PFS_SEL_STATUS = 3'h7
	} pfs_sel_t;

endpackage : pfs_pkg

// ### rtl/pfs_sync2.sv
`timescale 1ns/1ps
module pfs_sync2 #(
	parameter int WIDTH = 8
) (
	input  wire logic             i_mclk,
	input  wire logic             i_rst,
	input  wire logic [WIDTH-1:0] i_d,
	output logic      [WIDTH-1:0] o_q
);

	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] next_stage1;
	logic [WIDTH-1:0] next_q;

	// The first stage feeds only the second; nothing else may look at it.
	always_comb begin
		next_stage1 = i_d;
		next_q      = stage1;
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			stage1 <= '0;
			o_q    <= '0;
		end else begin
			stage1 <= next_stage1;
			o_q    <= next_q;
		end
	end

endmodule : pfs_sync2

// ### rtl/pfs_port0_func_sel.sv
// Our own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
// Notes on behaviour
// - Alternate select bits for pins 0, 1 and 3; only pin 3 chooses between two functions.
// - Pin 3 select: 0 irq0 input, 1 ADC trigger.
// - Alternate select register byte or bit access.
// - Both control registers reset to zero.
// - Mode register sets each port 0 pin mode.
// - Mode register byte or bit access.
// - Pin 3 mode: 0 port I/O, 1 alternate.
module pfs_port0_func_sel #(
	parameter logic [7:0] PIN_PRESENT = pfs_pkg::PFS_PIN_PRESENT
) (
	input  wire logic                        i_mclk,
	input  wire logic                        i_rst,
	input  wire logic [pfs_pkg::PFS_AW-1:0]  i_addr,
	input  wire logic [pfs_pkg::PFS_DW-1:0]  i_wdata,
	input  wire logic                        i_we,
	input  wire logic                        i_re,
	input  wire pfs_pkg::pfs_bitacc_t        i_bit,
	input  wire logic [pfs_pkg::PFS_DW-1:0]  i_pin,
	output logic      [pfs_pkg::PFS_DW-1:0]  o_rdata,
	output logic      [pfs_pkg::PFS_DW-1:0]  o_pin_out,
	output logic      [pfs_pkg::PFS_DW-1:0]  o_pin_oe,
	output logic      [pfs_pkg::PFS_DW-1:0]  o_hyst_en,
	output logic      [pfs_pkg::PFS_DW-1:0]  o_alt_pin,
	output pfs_pkg::pfs_alt_in_t             o_alt_in
);

	import pfs_pkg::*;

	// Software state.
	logic [PFS_DW-1:0] port0_mode_control;
	logic [PFS_DW-1:0] port0_alt_function_select;
	logic [PFS_DW-1:0] port_out;
	logic [PFS_DW-1:0] port_dir;
	logic [PFS_DW-1:0] status;
	logic [PFS_DW-1:0] next_port0_mode_control;
	logic [PFS_DW-1:0] next_port0_alt_function_select;
	logic [PFS_DW-1:0] next_port_out;
	logic [PFS_DW-1:0] next_port_dir;
	logic [PFS_DW-1:0] next_status;

	// Read path.
	logic [PFS_DW-1:0] next_rdata;

	// Pin side.
	logic [PFS_DW-1:0] pin_sync;
	logic [PFS_DW-1:0] next_pin_out;
	logic [PFS_DW-1:0] next_pin_oe;
	logic [PFS_DW-1:0] next_hyst_en;
	logic [PFS_DW-1:0] next_alt_pin;
	pfs_alt_in_t       next_alt_in;

	// Decode helpers.
	pfs_sel_t          sel;
	logic [PFS_DW-1:0] sel_bits;
	logic              bad_bit;
	logic [PFS_DW-1:0] stat_clr;
	logic [PFS_DW-1:0] stat_set;
	logic              pin3_mode_bit;
	logic              pin3_alt_select_bit;
	logic              port0_pin3;

	function automatic pfs_sel_t addr_sel(input logic [PFS_AW-1:0] a);
		pfs_sel_t s;
		s = PFS_SEL_NONE;
		if (a == PFS_ADDR_PORT_OUT) begin
			s = PFS_SEL_OUT;
		end else if (a == PFS_ADDR_PORT_IN) begin
			s = PFS_SEL_IN;
		end else if (a == PFS_ADDR_PORT_DIR) begin
			s = PFS_SEL_DIR;
		end else if (a == PFS_ADDR_MODE) begin
			s = PFS_SEL_MODE;
		end else if (a == PFS_ADDR_ALT_SEL) begin
			s = PFS_SEL_ALT;
		end else if (a == PFS_ADDR_ROUTE) begin
			s = PFS_SEL_ROUTE;
		end else if (a == PFS_ADDR_STATUS) begin
			s = PFS_SEL_STATUS;
		end
		return s;
	endfunction : addr_sel

	// Bits that exist in each register; absent pins hold zero after a write, though port_dir resets to all ones.
	function automatic logic [PFS_DW-1:0] sel_mask(input pfs_sel_t s);
		logic [PFS_DW-1:0] m;
		m = PFS_ZERO;
		case (s)
			PFS_SEL_OUT:    m = PFS_MASK_PORT & PIN_PRESENT;
			PFS_SEL_IN:     m = PFS_MASK_PORT & PIN_PRESENT;
			PFS_SEL_DIR:    m = PFS_MASK_PORT & PIN_PRESENT;
			PFS_SEL_MODE:   m = PFS_MASK_MODE & PIN_PRESENT;
			PFS_SEL_ALT:    m = PFS_MASK_ALT_SEL & PIN_PRESENT;
			PFS_SEL_ROUTE:  m = PFS_MASK_ROUTE;
			PFS_SEL_STATUS: m = PFS_MASK_STATUS;
			default:        m = PFS_ZERO;
		endcase
		return m;
	endfunction : sel_mask

	// Whole-byte write, or one bit changed by a single-bit operation.
	function automatic logic [PFS_DW-1:0] apply_write(
		input logic [PFS_DW-1:0] cur,
		input logic [PFS_DW-1:0] wd,
		input pfs_bitacc_t       b,
		input logic [PFS_DW-1:0] mask
	);
		logic [PFS_DW-1:0] nv;
		nv = cur;
		if (!b.en) begin
			nv = wd;
		end else begin
			case (b.op)
				PFS_BOP_WRITE:  nv[b.idx] = wd[0];
				PFS_BOP_SET:    nv[b.idx] = 1'b1;
				PFS_BOP_CLEAR:  nv[b.idx] = 1'b0;
				PFS_BOP_TOGGLE: nv[b.idx] = ~cur[b.idx];
				default:        nv = cur;
			endcase
		end
		return nv & mask;
	endfunction : apply_write

	// A single-bit read returns the chosen bit in bit 0.
	function automatic logic [PFS_DW-1:0] read_view(
		input logic [PFS_DW-1:0] val,
		input pfs_bitacc_t       b
	);
		logic [PFS_DW-1:0] r;
		r = val;
		if (b.en) begin
			r    = PFS_ZERO;
			r[0] = val[b.idx];
		end
		return r;
	endfunction : read_view

	// Pins come from outside the clock domain.
	pfs_sync2 #(
		.WIDTH (PFS_DW)
	) u_pin_sync (
		.i_mclk (i_mclk),
		.i_rst  (i_rst),
		.i_d    (i_pin),
		.o_q    (pin_sync)
	);

	assign pin3_mode_bit       = port0_mode_control[PFS_PIN3_IDX];
	assign pin3_alt_select_bit = port0_alt_function_select[PFS_PIN3_IDX];
	assign port0_pin3          = pin_sync[PFS_PIN3_IDX];

	assign sel      = addr_sel(i_addr);
	// The mask is held in a net so that a single bit of it can be picked.
	assign sel_bits = sel_mask(sel);
	assign bad_bit  = i_bit.en && ((i_we && !sel_bits[i_bit.idx])
	                  || (i_re && sel == PFS_SEL_NONE));

	// Register group: writes, and sticky error flags.
	always_comb begin
		next_port0_mode_control        = port0_mode_control;
		next_port0_alt_function_select = port0_alt_function_select;
		next_port_out                  = port_out;
		next_port_dir                  = port_dir;
		stat_clr                       = PFS_ZERO;
		stat_set                       = PFS_ZERO;
		if (i_we) begin
			if (sel == PFS_SEL_MODE) begin
				next_port0_mode_control = apply_write(port0_mode_control,
					i_wdata, i_bit, sel_mask(sel));
			end else if (sel == PFS_SEL_ALT) begin
				next_port0_alt_function_select = apply_write(
					port0_alt_function_select, i_wdata, i_bit,
					sel_mask(sel));
			end else if (sel == PFS_SEL_OUT) begin
				next_port_out = apply_write(port_out, i_wdata, i_bit,
					sel_mask(sel));
			end else if (sel == PFS_SEL_DIR) begin
				next_port_dir = apply_write(port_dir, i_wdata, i_bit,
					sel_mask(sel));
			end else if (sel == PFS_SEL_STATUS) begin
				// Ones clear; a bit operation clears where it would set.
				stat_clr = apply_write(PFS_ZERO, i_wdata, i_bit,
					sel_mask(sel));
			end
		end
		if ((i_we || i_re) && sel == PFS_SEL_NONE) begin
			stat_set[PFS_STAT_UNMAPPED] = 1'b1;
		end
		if (bad_bit) begin
			stat_set[PFS_STAT_BAD_BIT] = 1'b1;
		end
		// A new error in the clearing cycle survives the clear.
		next_status = ((status & ~stat_clr) | stat_set) & PFS_MASK_STATUS;
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			port0_mode_control        <= PFS_RST_MODE;
			port0_alt_function_select <= PFS_RST_ALT_SEL;
			port_out                  <= PFS_RST_OUT;
			port_dir                  <= PFS_RST_DIR;
			status                    <= PFS_RST_STATUS;
		end else begin
			port0_mode_control        <= next_port0_mode_control;
			port0_alt_function_select <= next_port0_alt_function_select;
			port_out                  <= next_port_out;
			port_dir                  <= next_port_dir;
			status                    <= next_status;
		end
	end

	// Read group: data stand only in the cycle after the strobe.
	always_comb begin
		next_rdata = PFS_ZERO;
		if (i_re) begin
			if (sel == PFS_SEL_MODE) begin
				next_rdata = read_view(port0_mode_control, i_bit);
			end else if (sel == PFS_SEL_ALT) begin
				next_rdata = read_view(port0_alt_function_select,
					i_bit);
			end else if (sel == PFS_SEL_OUT) begin
				next_rdata = read_view(port_out, i_bit);
			end else if (sel == PFS_SEL_DIR) begin
				next_rdata = read_view(port_dir, i_bit);
			end else if (sel == PFS_SEL_IN) begin
				// Output pins read back the latch, input pins the pin.
				next_rdata = read_view(((pin_sync & port_dir)
					| (port_out & ~port_dir)) & sel_mask(sel), i_bit);
			end else if (sel == PFS_SEL_ROUTE) begin
				next_rdata = read_view({o_hyst_en[PFS_DW-1:3],
					o_alt_pin[PFS_PIN3_IDX], o_alt_in.adc_trig,
					o_alt_in.irq0} & sel_mask(sel), i_bit);
			end else if (sel == PFS_SEL_STATUS) begin
				next_rdata = read_view(status, i_bit);
			end
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			o_rdata <= PFS_ZERO;
		end else begin
			o_rdata <= next_rdata;
		end
	end

	// Pin group: routing of inputs and drive of port outputs.
	always_comb begin
		// A pin in alternate mode is never driven by the port latch.
		next_pin_out = port_out & PIN_PRESENT & PFS_MASK_PORT;
		next_pin_oe  = ~port_dir & ~port0_mode_control & PIN_PRESENT
		               & PFS_MASK_PORT;
		// Input buffers switch to hysteresis in alternate mode only.
		next_hyst_en = port0_mode_control & PIN_PRESENT;
		next_alt_pin = pin_sync & port0_mode_control & PIN_PRESENT;
		next_alt_in.irq0     = pin3_mode_bit && !pin3_alt_select_bit
		                       && port0_pin3;
		next_alt_in.adc_trig = pin3_mode_bit && pin3_alt_select_bit
		                       && port0_pin3;
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			o_pin_out <= PFS_ZERO;
			o_pin_oe  <= PFS_ZERO;
			o_hyst_en <= PFS_ZERO;
			o_alt_pin <= PFS_ZERO;
			o_alt_in  <= '0;
		end else begin
			o_pin_out <= next_pin_out;
			o_pin_oe  <= next_pin_oe;
			o_hyst_en <= next_hyst_en;
			o_alt_pin <= next_alt_pin;
			o_alt_in  <= next_alt_in;
		end
	end

endmodule : pfs_port0_func_sel

// ### sim/pfs_port0_func_sel_checker.sv
`timescale 1ns/1ps
module pfs_port0_func_sel_checker #(
	parameter logic [7:0] PIN_PRESENT = pfs_pkg::PFS_PIN_PRESENT
) (
	input wire logic                       i_mclk,
	input wire logic                       i_rst,
	input wire logic [pfs_pkg::PFS_AW-1:0] i_addr,
	input wire logic [pfs_pkg::PFS_DW-1:0] i_wdata,
	input wire logic                       i_we,
	input wire logic                       i_re,
	input wire pfs_pkg::pfs_bitacc_t       i_bit,
	input wire logic [pfs_pkg::PFS_DW-1:0] i_pin,
	input wire logic [pfs_pkg::PFS_DW-1:0] o_rdata,
	input wire logic [pfs_pkg::PFS_DW-1:0] o_pin_out,
	input wire logic [pfs_pkg::PFS_DW-1:0] o_pin_oe,
	input wire logic [pfs_pkg::PFS_DW-1:0] o_hyst_en,
	input wire logic [pfs_pkg::PFS_DW-1:0] o_alt_pin,
	input wire pfs_pkg::pfs_alt_in_t       o_alt_in
);
	import pfs_pkg::*;
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_rst);
	logic mode_wr;
	assign mode_wr = i_we && i_addr == PFS_ADDR_MODE;
	property p_rst;
		$fell(i_rst) |-> o_hyst_en == PFS_ZERO && o_alt_in == 2'h0;
	endproperty
	a_rst: assert property (p_rst) else $error("outputs not cleared");
	property p_excl;
		!(o_alt_in.irq0 && o_alt_in.adc_trig);
	endproperty
	a_excl: assert property (p_excl) else $error("both alt inputs");
	property p_route;
		(o_alt_in.irq0 || o_alt_in.adc_trig) == o_alt_pin[3];
	endproperty
	a_route: assert property (p_route) else $error("pin3 lost");
	property p_idle;
		!o_hyst_en[3] |-> o_alt_in == 2'h0;
	endproperty
	a_idle: assert property (p_idle) else $error("alt input active");
	property p_noe;
		o_hyst_en[3] |-> !o_pin_oe[3];
	endproperty
	a_noe: assert property (p_noe) else $error("alt pin driven");
	property p_mbyte;
		(mode_wr && !i_bit.en) ##1 !mode_wr |=>
			o_hyst_en == ($past(i_wdata, 2) & PFS_MASK_MODE & PIN_PRESENT);
	endproperty
	a_mbyte: assert property (p_mbyte) else $error("mode byte");
	property p_mbit;
		(mode_wr && i_bit.en && i_bit.idx == 3'h3 &&
			i_bit.op == PFS_BOP_SET) ##1 !mode_wr |=>
			o_hyst_en[3] == PIN_PRESENT[3];
	endproperty
	a_mbit: assert property (p_mbit) else $error("mode bit set");
	property p_rdq;
		!i_re |=> o_rdata == PFS_ZERO;
	endproperty
	a_rdq: assert property (p_rdq) else $error("stray read data");
endmodule : pfs_port0_func_sel_checker

bind pfs_port0_func_sel pfs_port0_func_sel_checker #(
	.PIN_PRESENT(PIN_PRESENT)
) i_chk (
	.i_mclk(i_mclk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
	.i_we(i_we), .i_re(i_re), .i_bit(i_bit), .i_pin(i_pin),
	.o_rdata(o_rdata), .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe),
	.o_hyst_en(o_hyst_en), .o_alt_pin(o_alt_pin), .o_alt_in(o_alt_in)
);

// ### sim/tb_pfs_port0_func_sel.sv
`timescale 1ns/1ps
module tb_pfs_port0_func_sel;
	import pfs_pkg::*;
	logic              i_mclk  = 1'b0;
	logic              i_rst   = 1'b1;
	logic [PFS_AW-1:0] i_addr  = 8'h00;
	logic [PFS_DW-1:0] i_wdata = 8'h00;
	logic              i_we    = 1'b0;
	logic              i_re    = 1'b0;
	pfs_bitacc_t       i_bit   = '0;
	logic [PFS_DW-1:0] i_pin   = 8'h00;
	logic [PFS_DW-1:0] o_rdata;
	logic [PFS_DW-1:0] o_pin_out;
	logic [PFS_DW-1:0] o_pin_oe;
	logic [PFS_DW-1:0] o_hyst_en;
	logic [PFS_DW-1:0] o_alt_pin;
	pfs_alt_in_t       o_alt_in;
	int                error_cnt   = 0;
	int                check_count = 0;
	always #12.5 i_mclk = ~i_mclk;
	pfs_port0_func_sel i_dut (
		.i_mclk(i_mclk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_we(i_we), .i_re(i_re), .i_bit(i_bit), .i_pin(i_pin),
		.o_rdata(o_rdata), .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe),
		.o_hyst_en(o_hyst_en), .o_alt_pin(o_alt_pin), .o_alt_in(o_alt_in)
	);
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic wr(input logic [7:0] a, input logic [7:0] d,
		input pfs_bitacc_t b);
		@(posedge i_mclk);
		i_we    <= 1'b1;
		i_addr  <= a;
		i_wdata <= d;
		i_bit   <= b;
		@(posedge i_mclk);
		i_we <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input pfs_bitacc_t b,
		input logic [7:0] e);
		@(posedge i_mclk);
		i_re   <= 1'b1;
		i_addr <= a;
		i_bit  <= b;
		@(posedge i_mclk);
		i_re <= 1'b0;
		#1;
		check(o_rdata, e);
	endtask : rd
	// Output registers trail the control registers by one edge.
	task automatic settle(input int n);
		repeat (n) @(posedge i_mclk);
		#1;
	endtask : settle
	task automatic t_reset();
		rd(PFS_ADDR_MODE, '0, 8'h00);
		rd(PFS_ADDR_ALT_SEL, '0, 8'h00);
		check(o_hyst_en, 8'h00);
		check({6'h00, o_alt_in}, 8'h00);
	endtask : t_reset
	task automatic t_mode();
		wr(PFS_ADDR_MODE, 8'hff, '0);
		rd(PFS_ADDR_MODE, '0, 8'h7f);
		check(o_hyst_en, 8'h7f);
		wr(PFS_ADDR_MODE, 8'h00, '{1'b1, 3'h3, PFS_BOP_CLEAR});
		rd(PFS_ADDR_MODE, '0, 8'h77);
		rd(PFS_ADDR_MODE, '{1'b1, 3'h3, PFS_BOP_WRITE}, 8'h00);
		wr(PFS_ADDR_PORT_DIR, 8'h00, '0);
		settle(1);
		check(o_pin_oe, 8'h08);
		wr(PFS_ADDR_MODE, 8'h00, '{1'b1, 3'h3, PFS_BOP_SET});
		settle(1);
		check(o_pin_oe, 8'h00);
		check(o_hyst_en, 8'h7f);
	endtask : t_mode
	task automatic t_alt();
		pfs_bitop_t ops [5];
		logic [7:0] exp [5];
		ops = '{PFS_BOP_WRITE, PFS_BOP_SET, PFS_BOP_TOGGLE, PFS_BOP_TOGGLE,
			PFS_BOP_CLEAR};
		exp = '{8'h03, 8'h0b, 8'h03, 8'h0b, 8'h03};
		wr(PFS_ADDR_ALT_SEL, 8'hff, '0);
		rd(PFS_ADDR_ALT_SEL, '0, 8'h0b);
		for (int k = 0; k < 5; k++) begin
			wr(PFS_ADDR_ALT_SEL, 8'h00, '{1'b1, 3'h3, ops[k]});
			rd(PFS_ADDR_ALT_SEL, '0, exp[k]);
		end
		wr(PFS_ADDR_ALT_SEL, 8'h00, '0);
	endtask : t_alt
	task automatic t_route();
		@(posedge i_mclk);
		i_pin <= 8'h08;
		settle(4);
		check({6'h00, o_alt_in}, 8'h02);
		check(o_alt_pin, 8'h08);
		wr(PFS_ADDR_ALT_SEL, 8'h08, '0);
		settle(1);
		check({6'h00, o_alt_in}, 8'h01);
		wr(PFS_ADDR_MODE, 8'h00, '{1'b1, 3'h3, PFS_BOP_CLEAR});
		settle(1);
		check({6'h00, o_alt_in}, 8'h00);
		check(o_alt_pin, 8'h00);
	endtask : t_route
	task automatic t_port();
		wr(PFS_ADDR_PORT_OUT, 8'h05, '0);
		wr(PFS_ADDR_PORT_DIR, 8'h08, '0);
		settle(1);
		check(o_pin_out, 8'h05);
		check(o_pin_oe, 8'h00);
		rd(PFS_ADDR_PORT_IN, '0, 8'h0d);
		wr(PFS_ADDR_MODE, 8'h00, '{1'b1, 3'h3, PFS_BOP_SET});
		rd(PFS_ADDR_ROUTE, '0, 8'h06);
		wr(PFS_ADDR_ALT_SEL, 8'h00, '{1'b1, 3'h2, PFS_BOP_SET});
		rd(PFS_ADDR_STATUS, '0, 8'h03);
		rd(PFS_ADDR_ALT_SEL, '0, 8'h08);
		wr(PFS_ADDR_STATUS, 8'h03, '0);
		rd(PFS_ADDR_STATUS, '0, 8'h00);
	endtask : t_port
	task automatic conclude();
		$display("Checks %0d, errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : conclude
	initial begin
		repeat (4) @(posedge i_mclk);
		i_rst <= 1'b0;
		t_reset();
		t_mode();
		t_alt();
		t_route();
		rd(8'h55, '0, 8'h00);
		t_port();
		conclude();
	end
endmodule : tb_pfs_port0_func_sel
